// ==== design/rac_inventory.sv ====
/*
  Tag-side inventory anticollision: parses request bytes, checks the
  request, runs the slot sequence and times the reply delay.
  Assumes an RF front end that delivers decoded bytes, one-cycle SOF and
  EOF (rising edge) pulses and a CRC verdict valid with the EOF pulse.
*/
`timescale 1ns/1ps
`include "rac_defines.svh"

module rac_inventory
	import rac_pkg::*;
#(
	parameter int REPLY_WAIT_CYCLES = `RAC_T1_NOM_NS / `RAC_CLK_PERIOD_NS
)
(
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	input  wire logic        rx_sof,
	input  wire logic        rx_eof,
	input  wire logic        rx_byte_valid,
	input  wire logic [7:0]  rx_byte,
	input  wire logic        rx_crc_ok,
	input  wire logic [63:0] tag_uid,
	output logic             reply_start,
	output logic             reply_fast,
	output logic             reply_uid,
	output logic             pass_request,
	output logic             anticol_active,
	output logic [3:0]       current_slot_number,
	output logic             batch_armed,
	output logic [7:0]       family_id
);

	localparam int WW = $clog2(REPLY_WAIT_CYCLES + 1);

	////////////////////////////////////////////////////////////////////////
	rac_state_type state_reg;
	logic [4:0]    byte_cnt_reg;
	logic [7:0]    flags_reg;
	logic [7:0]    cmd_reg;
	logic [7:0]    mask_len_reg;
	logic [63:0]   mask_reg;
	logic [3:0]    slot_reg;
	logic          in_seq_reg;
	logic [WW-1:0] wait_reg;
	logic          reply_start_reg;
	logic          reply_fast_reg;
	logic          reply_uid_reg;
	logic          pass_reg;
	logic          armed_reg;
	logic [7:0]    family_reg;

	////////////////////////////////////////////////////////////////////////
	// field positions within the request
	wire       family_on = flags_reg[`RAC_FLG_FAMILY];                       // see RQ22
	wire       single_on = flags_reg[`RAC_FLG_SINGLE];                       // see RQ22
	wire [4:0] len_pos   = family_on ? `RAC_LEN_POS_AFI : `RAC_LEN_POS_PLAIN; // see RQ5
	wire [4:0] mask_bytes = 5'((9'(mask_len_reg) + 9'h007) >> 3);            // see RQ2
	wire [4:0] mask_idx  = byte_cnt_reg - len_pos - 5'h01;
	wire       at_family = family_on && byte_cnt_reg == `RAC_LEN_POS_PLAIN;  // see RQ5
	wire       at_len    = byte_cnt_reg == len_pos;                          // see RQ1
	// mask bytes end where the length says; anything after is the CRC
	wire       at_mask   = byte_cnt_reg > len_pos && mask_idx < mask_bytes
	                       && mask_idx < `RAC_MASK_MAX_BYTE;                 // see RQ4
	wire [4:0] expect_cnt = len_pos + 5'h01 + mask_bytes + `RAC_CRC_BYTES;   // see RQ4

	// command decode
	wire is_inv      = cmd_reg == `RAC_CMD_INVENTORY;
	wire is_init_inv = cmd_reg == `RAC_CMD_INV_INIT || cmd_reg == `RAC_CMD_FAST_INV_INIT;
	wire is_initiate = cmd_reg == `RAC_CMD_INITIATE || cmd_reg == `RAC_CMD_FAST_INITIATE;
	wire is_fast     = cmd_reg == `RAC_CMD_FAST_INV_INIT
	                   || cmd_reg == `RAC_CMD_FAST_INITIATE;                 // see RQ21

	// a malformed or corrupted inventory request leaves the tag silent
	wire req_ok = rx_crc_ok                                                  // see RQ25
	              && byte_cnt_reg == expect_cnt                              // see RQ4
	              && mask_len_reg <= `RAC_MASK_MAX_BITS
	              && flags_reg[`RAC_FLG_INVENTORY];                          // see RQ23
	wire start_seq = req_ok && (is_inv || (is_init_inv && armed_reg));       // see RQ20
	wire arm_req   = rx_crc_ok && is_initiate;

	// frame events: an SOF always wins over a coincident EOF
	wire sof_now   = rx_sof;
	wire eof_now   = rx_eof && !rx_sof;
	wire req_end   = state_reg == RAC_RECV && eof_now;
	wire wait_done = wait_reg == '0;
	wire last_slot = single_on || slot_reg == `RAC_LAST_SLOT;                // see RQ6

	////////////////////////////////////////////////////////////////////////
	// comparator: slot number stacked above the significant mask bits
	wire [7:0]  slot_bits = single_on ? 8'h00 : `RAC_SLOT_BITS;              // see RQ6
	wire [7:0]  cmp_width = slot_bits + mask_len_reg;
	wire [63:0] len_mask  = ~(~64'h0 << mask_len_reg);                       // see RQ3
	wire [63:0] cmp_mask  = ~(~64'h0 << cmp_width);                          // see RQ7
	wire [63:0] slot_sh   = {60'h0, slot_reg} << mask_len_reg;
	wire [63:0] pattern   = slot_sh | (mask_reg & len_mask);                 // see RQ3
	wire        uid_match = ((tag_uid ^ pattern) & cmp_mask) == 64'h0;       // see RQ7

	////////////////////////////////////////////////////////////////////////
	// next state; EOF depth is not seen here, so 10% and 100% slot EOFs
	// advance alike
	rac_state_type state_next;
	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			RAC_IDLE  : state_next = state_reg;
			RAC_RECV  :
				if (eof_now)
					state_next = (start_seq || arm_req) ? RAC_DELAY : RAC_IDLE;
			RAC_DELAY :
				if (wait_done)
					state_next = in_seq_reg ? RAC_SLOT : RAC_IDLE;      // see RQ14
			RAC_SLOT  :
				if (eof_now)
					state_next = last_slot ? RAC_IDLE : RAC_DELAY;      // see RQ17, RQ24
		endcase
		if (sof_now)
			state_next = RAC_RECV;                                   // see RQ10
	end

	////////////////////////////////////////////////////////////////////////
	// sequencer and request capture
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_reg    <= RAC_IDLE;
			byte_cnt_reg <= 5'h00;
			flags_reg    <= 8'h00;
			cmd_reg      <= 8'h00;
			mask_len_reg <= 8'h00;
			mask_reg     <= 64'h0;
			family_reg   <= 8'h00;
		end
		else
		begin
			state_reg <= state_next;
			if (sof_now)
			begin
				byte_cnt_reg <= 5'h00;                               // see RQ11
				mask_reg     <= 64'h0;
				mask_len_reg <= 8'h00;
			end
			else if (state_reg == RAC_RECV && rx_byte_valid)
			begin
				// count saturates so an overlong frame can never look well formed
				if (byte_cnt_reg != 5'h1F)
					byte_cnt_reg <= byte_cnt_reg + 5'h01;
				if (byte_cnt_reg == `RAC_IDX_FLAGS)
					flags_reg <= rx_byte;
				if (byte_cnt_reg == `RAC_IDX_CMD)
					cmd_reg <= rx_byte;
				if (at_family)
					family_reg <= rx_byte;                           // see RQ5
				if (at_len)
					mask_len_reg <= rx_byte;                         // see RQ1
				if (at_mask)
					mask_reg[mask_idx[2:0] * 8 +: 8] <= rx_byte;     // see RQ2
			end
		end
	end

	// slot number and sequence flag
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			slot_reg   <= 4'h0;
			in_seq_reg <= 1'b0;
		end
		else if (sof_now)
		begin
			in_seq_reg <= 1'b0;                                      // see RQ10
		end
		else if (req_end)
		begin
			slot_reg   <= 4'h0;                                      // see RQ8, RQ11
			in_seq_reg <= start_seq;
		end
		else if (state_reg == RAC_SLOT && eof_now)
		begin
			if (last_slot)
				in_seq_reg <= 1'b0;                                  // see RQ24
			else
				slot_reg <= slot_reg + 4'h1;                         // see RQ9
		end
	end

	// reply delay: nominal count sits mid-window, well inside the tolerance
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			wait_reg <= '0;
		else if (state_next == RAC_DELAY && state_reg != RAC_DELAY)
			wait_reg <= WW'(REPLY_WAIT_CYCLES - 1);                  // see RQ14, RQ18
		else if (!wait_done)
			wait_reg <= wait_reg - WW'(1);
	end

	////////////////////////////////////////////////////////////////////////
	// reply strobes; only anticollision commands are timed here, write-type
	// requests go out on pass_request and keep their own timing
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			reply_start_reg <= 1'b0;
			reply_fast_reg  <= 1'b0;
			reply_uid_reg   <= 1'b0;
			pass_reg        <= 1'b0;
			armed_reg       <= 1'b0;
		end
		else
		begin
			reply_start_reg <= state_reg == RAC_DELAY && wait_done && !sof_now
			                   && (!in_seq_reg || uid_match);             // see RQ7, RQ14
			pass_reg        <= req_end && !(is_inv || is_init_inv || is_initiate); // see RQ19
			if (req_end)
			begin
				reply_fast_reg <= is_fast;                           // see RQ21
				reply_uid_reg  <= start_seq;
				if (arm_req)
					armed_reg <= 1'b1;                               // see RQ20
			end
		end
	end

	assign reply_start         = reply_start_reg;
	assign reply_fast          = reply_fast_reg;
	assign reply_uid           = reply_uid_reg;
	assign pass_request        = pass_reg;
	assign anticol_active      = in_seq_reg;
	assign current_slot_number = slot_reg;
	assign batch_armed         = armed_reg;
	assign family_id           = family_reg;

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	sequence s_slot_eof;
		state_reg == RAC_SLOT && eof_now;
	endsequence

	sequence s_leave_quiet;
		state_reg == RAC_IDLE && !in_seq_reg ##1 !reply_start_reg;
	endsequence

	a_seq_start_zero: assert property (req_end && start_seq |=>          // see RQ8
		state_reg == RAC_DELAY && slot_reg == 4'h0 && in_seq_reg)
		else $error("slot sequence did not start at slot zero");

	a_bad_req_quiet: assert property (req_end && !req_ok && !arm_req |=>  // see RQ23
		state_reg == RAC_IDLE && !in_seq_reg ##1 !reply_start_reg)
		else $error("invalid request started a sequence");

	a_crc_gate: assert property (req_end && !rx_crc_ok |=> !in_seq_reg)  // see RQ25
		else $error("crc failure started anticollision");

	a_batch_gate: assert property (req_end && is_init_inv && !armed_reg   // see RQ20
		|=> !in_seq_reg)
		else $error("initiated inventory answered while unarmed");

	a_sof_abort: assert property (sof_now |=>                             // see RQ10
		state_reg == RAC_RECV && !in_seq_reg && byte_cnt_reg == 5'h00)
		else $error("sof did not abort the sequence");

	a_slot_advance: assert property (s_slot_eof and !last_slot |=>        // see RQ9
		state_reg == RAC_DELAY && slot_reg == $past(slot_reg) + 4'h1)
		else $error("slot number did not advance");

	a_last_slot_end: assert property (s_slot_eof and last_slot |=>        // see RQ24
		s_leave_quiet)
		else $error("sequence continued past the last slot");

	a_reply_after_wait: assert property (reply_start_reg |->             // see RQ14
		$past(state_reg) == RAC_DELAY && $past(wait_reg) == '0)
		else $error("reply issued before the delay ran out");

	a_reply_match: assert property (state_reg == RAC_DELAY && wait_done   // see RQ7
		&& in_seq_reg && !sof_now |=> reply_start_reg == $past(uid_match))
		else $error("reply does not follow the uid comparison");

	a_single_slot: assert property (in_seq_reg && single_on |->          // see RQ6
		slot_reg == 4'h0)
		else $error("single-slot sequence left slot zero");

	a_fast_rate: assert property (reply_start_reg |-> reply_fast_reg == is_fast) // see RQ21
		else $error("reply rate does not follow the command");

	a_delay_window: assert property ($rose(state_reg == RAC_DELAY) |->   // see RQ18
		wait_reg == WW'(REPLY_WAIT_CYCLES - 1))
		else $error("reply delay loaded with the wrong count");

endmodule

// ==== design/rac_defines.svh ====
/*
  Constants of the tag-side inventory anticollision block: command codes,
  request flag positions, field sizes and reply timing.
  Assumes it is included by bare name from the package and the design file.
*/
// Behaviour
// RQ1 - reader puts 8-bit mask length then mask value right after the command
// RQ2 - mask length counts significant mask bits; mask sent LSB first, whole bytes
// RQ3 - mask padded with zero bits above its MSB; tag drops padding before comparing
// RQ4 - next field starts on byte boundary; mask 0 to 8 bytes, then 16-bit CRC
// RQ5 - optional family byte between command and mask length, when family flag set
// RQ6 - single-slot flag gives one slot, no slot bits; else 16 slots, 4 bits
// RQ7 - answer only if UID low bits equal slot number above significant mask bits
// RQ8 - slot zero starts at the request EOF with slot number zero
// RQ9 - lone EOF below last slot increments slot number and compares again
// RQ10 - an SOF during the slots abandons anticollision; new request decoded normally
// RQ11 - every new inventory request restarts slot numbering at zero
// RQ12 - reader waits for a whole reply frame before the next slot EOF
// RQ13 - with no reply seen, reader may send the slot EOF after its wait
// RQ14 - tag waits its reply delay after EOF before replying or changing slot
// RQ15 - reader waits at least 309.2 us after a reply before next EOF
// RQ16 - silent-slot reader wait: max reply delay plus reply SOF or nominal time
// RQ17 - slot EOFs may be 10% or 100% modulated; tag accepts both
// RQ18 - tag timings hold within plus or minus 32 carrier periods
// RQ19 - maximum reply delay does not govern write-type requests
// RQ20 - initiated inventory answered only when batch-armed by an earlier initiate
// RQ21 - fast initiate variants double the reply data rate
// RQ22 - with inventory flag, flag bit 5 is family filter, bit 6 single slot
// RQ23 - an inventory request with an error gets no reply at all
// RQ24 - EOF in the last slot ends the sequence with no further answer
// RQ25 - CRC failure makes the request invalid; no anticollision starts
`ifndef RAC_DEFINES_SVH
`define RAC_DEFINES_SVH

`define RAC_CMD_INVENTORY     8'h01
`define RAC_CMD_INV_INIT      8'hD1
`define RAC_CMD_FAST_INV_INIT 8'hC1
`define RAC_CMD_INITIATE      8'hD2
`define RAC_CMD_FAST_INITIATE 8'hC2

// flag bit positions, counted from zero (bit 3, 5, 6 in one-based terms)
`define RAC_FLG_INVENTORY 2
`define RAC_FLG_FAMILY    4
`define RAC_FLG_SINGLE    5

`define RAC_IDX_FLAGS     5'h00
`define RAC_IDX_CMD       5'h01
`define RAC_LEN_POS_PLAIN 5'h02
`define RAC_LEN_POS_AFI   5'h03
`define RAC_CRC_BYTES     5'h02
`define RAC_MASK_MAX_BITS 8'h40
`define RAC_MASK_MAX_BYTE 5'h08
`define RAC_SLOT_BITS     8'h04
`define RAC_LAST_SLOT     4'hF

// reply delay figures in ns, clock period in ns, carrier tolerance in ns
`define RAC_CLK_PERIOD_NS 10
`define RAC_T1_MIN_NS     318600
`define RAC_T1_NOM_NS     320900
`define RAC_T1_MAX_NS     323300
`define RAC_CARRIER_KHZ   13560
`define RAC_TOL_NS        ((32 * 1000000) / `RAC_CARRIER_KHZ)

`endif

// ==== design/rac_pkg.sv ====
/*
  Types of the inventory anticollision block.
  Assumes the defines header sits next to it.
*/
`include "rac_defines.svh"

package rac_pkg;

	// request/slot sequencer states
	typedef enum logic [1:0]
	{
		RAC_IDLE  = 2'b00,
		RAC_RECV  = 2'b01,
		RAC_DELAY = 2'b10,
		RAC_SLOT  = 2'b11
	} rac_state_type;

endpackage

// ==== verification/rac_reader.sv ====
/*
  Reader-side model: puts request frames and slot markers on the
  tag's decoded-frame inputs.
  Assumes the tag block and this model share one core clock.
*/
`timescale 1ns/1ps

module rac_reader
(
	input  wire logic       core_clk,
	output logic            rx_sof,
	output logic            rx_eof,
	output logic            rx_byte_valid,
	output logic [7:0]      rx_byte,
	output logic            rx_crc_ok
);
	// quiet lines at time zero
	initial
	begin
		rx_sof = 1'b0;
		rx_eof = 1'b0;
		rx_byte_valid = 1'b0;
		rx_byte = 8'h00;
		rx_crc_ok = 1'b0;
	end

	//////////////////////////////////////////////////////////////////
	// byte order is the caller's; layout is kept there
	task automatic send_frame(input logic [7:0] fr[$], input logic ok);
		@(posedge core_clk);
		rx_sof <= 1'b1;
		@(posedge core_clk);
		rx_sof <= 1'b0;
		foreach (fr[i])
		begin
			rx_byte_valid <= 1'b1;
			rx_byte <= fr[i];
			@(posedge core_clk);
		end
		// released data shows the inverse, never a stale byte
		rx_byte_valid <= 1'b0;
		rx_byte <= ~rx_byte;
		rx_eof <= 1'b1;
		rx_crc_ok <= ok;
		@(posedge core_clk);
		rx_eof <= 1'b0;
		rx_crc_ok <= ~ok;
	endtask

	// called only after the reply window closed
	// depth of modulation is not visible here
	task automatic slot_eof();
		@(posedge core_clk);
		rx_eof <= 1'b1;
		@(posedge core_clk);
		rx_eof <= 1'b0;
	endtask
endmodule

// ==== verification/rac_inventory_tb_top.sv ====
/*
  Self-checking bench of the inventory anticollision block.
  Assumes the package and defines header are compiled first.
*/
`timescale 1ns/1ps
`include "rac_defines.svh"

module rac_inventory_tb_top;
	import rac_pkg::*;
	localparam int N = 20;
	logic        core_clk, sys_rst, rx_sof, rx_eof, rx_byte_valid, rx_crc_ok;
	logic [7:0]  rx_byte, family_id;
	logic [63:0] tag_uid;
	logic        reply_start, reply_fast, reply_uid, pass_request;
	logic        anticol_active, batch_armed;
	logic [3:0]  current_slot_number;
	logic [31:0] seed;
	int          bad_count, cmp_count, rep_at;

	rac_inventory #(.REPLY_WAIT_CYCLES(N)) DUT (.core_clk(core_clk), .sys_rst(sys_rst),
		.rx_sof(rx_sof), .rx_eof(rx_eof), .rx_byte_valid(rx_byte_valid),
		.rx_byte(rx_byte), .rx_crc_ok(rx_crc_ok), .tag_uid(tag_uid),
		.reply_start(reply_start), .reply_fast(reply_fast), .reply_uid(reply_uid),
		.pass_request(pass_request), .anticol_active(anticol_active),
		.current_slot_number(current_slot_number), .batch_armed(batch_armed),
		.family_id(family_id));
	rac_reader rdr (.core_clk(core_clk), .rx_sof(rx_sof), .rx_eof(rx_eof),
		.rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .rx_crc_ok(rx_crc_ok));

	initial core_clk = 1'b0;
	always #5 core_clk = ~core_clk;

	//////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// expected answer: low uid bits against slot above the mask
	function automatic logic hit(logic [63:0] u, logic [3:0] sn, int len,
		logic [63:0] mk, logic one);
		logic [127:0] v;
		logic [127:0] m;
		v = one ? {64'h0, mk} : ({64'h0, mk} | ({124'h0, sn} << len));
		// bits beyond the 64-bit uid take no part in the comparison
		m = ((128'h1 << (len + (one ? 0 : 4))) - 128'h1) & {64'h0, ~64'h0};
		return ((v ^ {64'h0, u}) & m) == 128'h0;
	endfunction

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// count reply pulses over one reply window; rep_at keeps the first one's cycle
	task automatic replies(output int n);
		n = 0;
		rep_at = -1;
		for (int i = 0; i < N + 4; i++)
		begin
			@(negedge core_clk);
			if (reply_start === 1'b1 && n == 0)
				rep_at = i;
			n += (reply_start === 1'b1);
		end
	endtask

	// a negative length leaves out the length and mask fields
	task automatic inv(input logic [7:0] fl, cmd, fam, input int len,
		input logic [63:0] mk, input logic ok);
		logic [7:0]  fr[$];
		logic [63:0] t;
		fr = {fl, cmd};
		if (fl[4] && len >= 0)
			fr.push_back(fam);
		if (len >= 0)
			fr.push_back(len[7:0]);
		for (int i = 0; i < (len + 7) / 8; i++)
		begin
			t = mk >> (8 * i);
			fr.push_back(t[7:0]);
		end
		fr.push_back(8'hA5);
		fr.push_back(8'h5A);
		rdr.send_frame(fr, ok);
	endtask

	task automatic sweep(input int len, input logic [63:0] mk, input logic one,
		input int stop);
		int n;
		for (int s = 0; s < stop; s++)
		begin
			replies(n);
			check(anticol_active, 1'b1);
			check(current_slot_number, s[3:0]);
			check(reply_uid, 1'b1);
			check(n, hit(tag_uid, s[3:0], len, mk, one));
			if (hit(tag_uid, s[3:0], len, mk, one))
				check(rep_at, N);
			rdr.slot_eof();
		end
	endtask

	//////////////////////////////////////////////////////////////////
	// watchdog: more than ten times the expected run length
	initial
	begin
		#400000;
		bad_count++;
		test_done();
	end

	initial
	begin
		logic [63:0] u, mk;
		logic [31:0] r;
		logic        one;
		int          len, n, stop;
		seed = 32'h00006BC3;
		sys_rst = 1'b1;
		tag_uid = 64'h0;
		repeat (3) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(negedge core_clk);
		check({reply_start, reply_fast, reply_uid, pass_request, anticol_active,
			batch_armed, current_slot_number, family_id}, 18'h0);
		// random inventories; odd rounds aim the mask at the uid
		for (int k = 0; k < 10; k++)
		begin
			r = xs();
			u = {xs(), xs()};
			one = r[0] && k != 3;
			len = r[31:16] % 65;
			mk = k[0] ? u : {xs(), xs()};
			mk &= (64'h1 << len) - 64'h1;
			stop = k == 3 ? 6 : (one ? 1 : 16);
			@(posedge core_clk);
			tag_uid <= u;
			inv({2'b00, one, r[4], 4'h4}, `RAC_CMD_INVENTORY, r[15:8], len, mk, 1'b1);
			if (r[4])
				check(family_id, r[15:8]);
			sweep(len, mk, one, stop);
			check(reply_fast, 1'b0);
			if (k == 3)
			begin
				// sof in mid sequence: other command runs instead
				inv(8'h02, 8'h20, 8'h00, 0, 64'h0, 1'b1);
				n = 0;
				repeat (3)
				begin
					@(negedge core_clk);
					n += (pass_request === 1'b1);
				end
				check(n, 1);
			end
			else
			begin
				replies(n);
				check(n, 0);
			end
			check(anticol_active, 1'b0);
		end
		// refused: bad crc, oversize mask, no inventory flag, unarmed batch
		for (int c = 0; c < 4; c++)
		begin
			inv(c == 2 ? 8'h20 : 8'h24, c == 3 ? `RAC_CMD_INV_INIT : `RAC_CMD_INVENTORY,
				8'h00, c == 1 ? 65 : 0, 64'h0, c != 0);
			replies(n);
			check(n, 0);
			check(anticol_active, 1'b0);
		end
		// plain then fast variants of initiate and initiated inventory
		for (int c = 0; c < 2; c++)
		begin
			inv(8'h02, c ? `RAC_CMD_FAST_INITIATE : `RAC_CMD_INITIATE, 8'h00, -1,
				64'h0, 1'b1);
			replies(n);
			check(n, 1);
			check(rep_at, N);
			check({batch_armed, reply_uid, reply_fast}, {2'b10, c[0]});
			inv(8'h24, c ? `RAC_CMD_FAST_INV_INIT : `RAC_CMD_INV_INIT, 8'h00, 0,
				64'h0, 1'b1);
			sweep(0, 64'h0, 1'b1, 1);
			check(reply_fast, c[0]);
			replies(n);
			check(n, 0);
		end
		test_done();
	end
endmodule
